// ===== src/ufc_ctrl.sv
// UART FIFO control, interrupt identification, interrupt enable and modem control
// Overview of operation
// - FIFO enable on; clearing it flushes both
// - Any FIFO mode change empties both FIFOs
// - Other FIFO bits ignored unless enable set; code also needs it set before the write
// - Bit 1 flushes receive FIFO, self-clearing
// - Bit 2 flushes transmit FIFO, self-clearing
// - Bit 3 no effect; bits 4, 5 reserved
// - Bits 7:6 pick trigger 1/4/8/14 bytes
// - Priority: line, data/timeout, transmit, modem
// - Identification frozen during its read access
// - Ident bit 0 low when interrupt pending
// - Ident bits 3:0 encode the pending source
// - Ident bit 3 only for FIFO time-out
// - Ident bits 5:4 zero, 7:6 FIFO mode
// - Time-out after four idle character times
// - Transmit-empty cleared by write or ident read
// - Enable bits 0-3 select sources; 7:4 zero
// - Masked sources hidden, status still updates
// - Terminal-ready and request-to-send pins inverted
// - Spare output bit readable; bits 7:5 zero
// - Control bit 3 gates interrupt pin
// - Loopback: mark out, inputs cut, lines mapped
// - Loopback interrupts normal, pins float
`timescale 1ns/10ps
`include "ufc_defines.svh"

module ufc_ctrl
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Rest of the UART
  input wire ufc_pkg::ufc_evt_t evt_i,
  input wire logic [`UFC_CNT_W-1:0] rx_count_i,
  input wire logic tx_shift_i,
  output ufc_pkg::ufc_ctl_t ctl_o,
  output logic rx_serial_o,
  output logic [3:0] modem_lines_o,
  // Line side pins
  input wire logic serial_in_pin_i,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic bell_signal_in_n_i,
  input wire logic carrier_detect_in_n_i,
  output logic serial_out_pin_o,
  output logic dtr_n_o,
  output logic rts_n_o,
  output logic interrupt_line_a_o,
  output logic interrupt_line_a_oe_o,
  output logic interrupt_line_b_o,
  output logic interrupt_line_b_oe_o
);

  // Registers
  logic fifo_enable_bit;
  logic [1:0] trig_sel;
  logic rx_flush;
  logic tx_flush;
  logic [3:0] interrupt_enable_reg;
  logic [4:0] modem_control_reg;
  logic line_pend;
  logic thre_pend;
  logic modem_pend;
  logic tx_empty_d;
  logic [3:0] lines_d;
  logic lines_primed;
  logic [7:0] ident_shown;
  logic [7:0] rd_data;
  logic wr_pend;
  logic [`UFC_ADDR_W-1:0] wr_addr;
  logic [`UFC_SYNC_W-1:0] pins_sync;
  logic tout_flag;

  // Bus decode
  wire logic bus_take = hsel_i && htrans_i[1] && hready_i;
  wire logic [`UFC_ADDR_W-1:0] a_addr = haddr_i[`UFC_ADDR_W-1:0];
  wire logic rd_take = bus_take && !hwrite_i;
  wire logic wr_take = bus_take && hwrite_i;
  wire logic hit_ier = (a_addr == `UFC_OFS_IER);
  wire logic hit_iir = (a_addr == `UFC_OFS_IIR);
  wire logic hit_mcr = (a_addr == `UFC_OFS_MCR);
  wire logic iir_read = rd_take && hit_iir;
  wire logic [7:0] wbyte = hwdata_i[7:0];
  wire logic fcr_wr = wr_pend && (wr_addr == `UFC_OFS_IIR);
  wire logic ier_wr = wr_pend && (wr_addr == `UFC_OFS_IER);
  wire logic mcr_wr = wr_pend && (wr_addr == `UFC_OFS_MCR);

  // FIFO control decode
  wire logic new_en = wbyte[`UFC_FCR_EN];
  wire logic mode_change = fcr_wr && (new_en != fifo_enable_bit);
  wire logic fcr_prog = fcr_wr && fifo_enable_bit && new_en;
  wire logic loop_on = modem_control_reg[`UFC_MCR_LOOP];

  // Synchronised line inputs
  wire logic sin_s = pins_sync[0];
  wire logic cts_s = pins_sync[1];
  wire logic dsr_s = pins_sync[2];
  wire logic ri_s = pins_sync[3];
  wire logic dcd_s = pins_sync[4];

  ufc_sync u_sync
  (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .async_i({carrier_detect_in_n_i, bell_signal_in_n_i, dsr_n_i, cts_n_i, serial_in_pin_i}),
    .sync_o(pins_sync)
  );

  // Modem status view {dcd, ri, dsr, cts}, from pins or looped control bits
  wire logic [3:0] lines_ext = {~dcd_s, ~ri_s, ~dsr_s, ~cts_s};
  wire logic [3:0] lines_loop = {modem_control_reg[`UFC_MCR_IRQEN],
    modem_control_reg[`UFC_MCR_SPARE], modem_control_reg[`UFC_MCR_DTR],
    modem_control_reg[`UFC_MCR_RTS]};
  wire logic [3:0] lines_now = loop_on ? lines_loop : lines_ext;
  // Ring trailing edge: complement falls when the ring input returns high
  wire logic [3:0] lines_chg = lines_now ^ lines_d;
  wire logic modem_event = lines_primed && (lines_chg[0] || lines_chg[1] || lines_chg[3]
    || (lines_d[2] && !lines_now[2]));

  // Receive data and time-out conditions
  wire logic [`UFC_CNT_W-1:0] trig_bytes =
    (trig_sel == 2'h0) ? `UFC_TRIG_00 :
    (trig_sel == 2'h1) ? `UFC_TRIG_01 :
    (trig_sel == 2'h2) ? `UFC_TRIG_10 : `UFC_TRIG_11;
  wire logic rx_nonempty = (rx_count_i != {`UFC_CNT_W{1'b0}});
  // Stays active from the count reaching the level until reads bring it below
  wire logic data_avail = fifo_enable_bit ? (rx_count_i >= trig_bytes) : rx_nonempty;
  wire logic rx_activity = evt_i.rx_push || evt_i.rx_read;

  ufc_timeout u_timeout
  (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .fifo_mode_i(fifo_enable_bit),
    .rx_nonempty_i(rx_nonempty),
    .activity_i(rx_activity),
    .char_tick_i(evt_i.char_tick),
    .clear_i(evt_i.rx_read),
    .timeout_o(tout_flag)
  );

  // Enabled sources only
  wire logic en_line = line_pend && interrupt_enable_reg[`UFC_IER_LINE];
  wire logic en_data = data_avail && interrupt_enable_reg[`UFC_IER_DATA];
  wire logic en_tout = tout_flag && interrupt_enable_reg[`UFC_IER_DATA];
  wire logic en_thre = thre_pend && interrupt_enable_reg[`UFC_IER_THRE];
  wire logic en_modem = modem_pend && interrupt_enable_reg[`UFC_IER_MODEM];
  wire logic any_pend = en_line || en_data || en_tout || en_thre || en_modem;

  // Fixed priority choice
  wire ufc_pkg::ufc_src_t src_live =
    en_line ? ufc_pkg::SRC_LINE :
    en_data ? ufc_pkg::SRC_DATA :
    en_tout ? ufc_pkg::SRC_TOUT :
    en_thre ? ufc_pkg::SRC_THRE :
    en_modem ? ufc_pkg::SRC_MODEM : ufc_pkg::SRC_NONE;

  logic [3:0] id_code;
  always_comb
  begin
    case (src_live)
      ufc_pkg::SRC_LINE: id_code = `UFC_ID_LINE;
      ufc_pkg::SRC_DATA: id_code = `UFC_ID_DATA;
      ufc_pkg::SRC_TOUT: id_code = `UFC_ID_TOUT;
      ufc_pkg::SRC_THRE: id_code = `UFC_ID_THRE;
      ufc_pkg::SRC_MODEM: id_code = `UFC_ID_MODEM;
      default: id_code = `UFC_ID_NONE;
    endcase
  end

  wire logic [1:0] fifo_bits = fifo_enable_bit ? `UFC_IIR_FIFO_BITS : 2'h0;
  wire logic [7:0] ident_live = {fifo_bits, 2'h0, id_code};

  // Indication is sampled when the read is taken and held while it runs
  wire logic [7:0] next_ident = iir_read ? ident_live : ident_shown;
  wire logic thre_by_ident = iir_read && (src_live == ufc_pkg::SRC_THRE);

  logic [7:0] rd_mux;
  always_comb
  begin
    if (hit_iir)
      rd_mux = next_ident;
    else if (hit_ier)
      rd_mux = {4'h0, interrupt_enable_reg};
    else if (hit_mcr)
      rd_mux = {3'h0, modem_control_reg};
    else
      rd_mux = `UFC_ZERO8;
  end

  // Bus pipeline: address phase captured, write done in data phase
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      wr_pend <= 1'b0;
      wr_addr <= {`UFC_ADDR_W{1'b0}};
      rd_data <= `UFC_ZERO8;
    end
    else
    begin
      wr_pend <= wr_take;
      wr_addr <= wr_take ? a_addr : wr_addr;
      rd_data <= rd_take ? rd_mux : rd_data;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      ident_shown <= {4'h0, `UFC_ID_NONE};
    end
    else if (iir_read)
    begin
      ident_shown <= ident_live;
    end
  end

  // FIFO control register
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      fifo_enable_bit <= 1'b0;
      trig_sel <= 2'h0;
    end
    else if (fcr_wr)
    begin
      fifo_enable_bit <= new_en;
      if (fcr_prog)
        trig_sel <= wbyte[`UFC_FCR_TRIG_HI:`UFC_FCR_TRIG_LO];
    end
  end

  // Flushes are single-cycle pulses; bits 3 to 5 have no storage
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      rx_flush <= 1'b0;
      tx_flush <= 1'b0;
    end
    else
    begin
      rx_flush <= mode_change || (fcr_prog && wbyte[`UFC_FCR_RXFL]);
      tx_flush <= mode_change || (fcr_prog && wbyte[`UFC_FCR_TXFL]);
    end
  end

  // Enable and modem control registers
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      interrupt_enable_reg <= `UFC_ZERO4;
      modem_control_reg <= 5'h00;
    end
    else
    begin
      if (ier_wr)
        interrupt_enable_reg <= wbyte[3:0];
      if (mcr_wr)
        modem_control_reg <= wbyte[4:0];
    end
  end

  // Sticky sources: a new event in the clearing cycle wins
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      line_pend <= 1'b0;
      thre_pend <= 1'b0;
      modem_pend <= 1'b0;
      tx_empty_d <= 1'b0;
    end
    else
    begin
      tx_empty_d <= evt_i.tx_empty;
      if (evt_i.line_err)
        line_pend <= 1'b1;
      else if (evt_i.lsr_read)
        line_pend <= 1'b0;
      if (evt_i.tx_empty && !tx_empty_d)
        thre_pend <= 1'b1;
      else if (evt_i.thr_write || thre_by_ident)
        thre_pend <= 1'b0;
      if (modem_event)
        modem_pend <= 1'b1;
      else if (evt_i.msr_read)
        modem_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      lines_d <= `UFC_ZERO4;
      lines_primed <= 1'b0;
    end
    else
    begin
      lines_d <= lines_now;
      lines_primed <= 1'b1;
    end
  end

  // Line side pins
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      serial_out_pin_o <= 1'b1;
      dtr_n_o <= 1'b1;
      rts_n_o <= 1'b1;
      interrupt_line_a_o <= 1'b0;
      interrupt_line_a_oe_o <= 1'b1;
      rx_serial_o <= 1'b1;
    end
    else
    begin
      serial_out_pin_o <= loop_on ? 1'b1 : tx_shift_i;
      rx_serial_o <= loop_on ? tx_shift_i : sin_s;
      dtr_n_o <= loop_on ? 1'b1 : !modem_control_reg[`UFC_MCR_DTR];
      rts_n_o <= loop_on ? 1'b1 : !modem_control_reg[`UFC_MCR_RTS];
      interrupt_line_a_o <= any_pend && modem_control_reg[`UFC_MCR_IRQEN];
      interrupt_line_a_oe_o <= !loop_on;
    end
  end

  // Both request lines carry the same request; board wiring picks one
  assign interrupt_line_b_o = interrupt_line_a_o;
  assign interrupt_line_b_oe_o = interrupt_line_a_oe_o;

  assign modem_lines_o = lines_d;
  assign ctl_o.fifo_mode = fifo_enable_bit;
  assign ctl_o.rx_flush = rx_flush;
  assign ctl_o.tx_flush = tx_flush;
  assign ctl_o.trig_sel = trig_sel;
  assign ctl_o.loopback = loop_on;

  // Zero wait states, always OKAY; unmapped reads return zero
  assign hrdata_o = {24'h000000, rd_data};
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

endmodule

// ===== src/ufc_defines.svh
// Register map, field positions and constants for the UART FIFO/interrupt/modem control block
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH

// Byte offsets on the register bus
`define UFC_OFS_IER 8'h04
`define UFC_OFS_IIR 8'h08
`define UFC_OFS_MCR 8'h10
`define UFC_ADDR_W 8

// FIFO control fields
`define UFC_FCR_EN 0
`define UFC_FCR_RXFL 1
`define UFC_FCR_TXFL 2
`define UFC_FCR_TRIG_LO 6
`define UFC_FCR_TRIG_HI 7

// Receive trigger levels in bytes
`define UFC_TRIG_00 5'h01
`define UFC_TRIG_01 5'h04
`define UFC_TRIG_10 5'h08
`define UFC_TRIG_11 5'h0E

// Interrupt identification codes, bits 3:0
`define UFC_ID_NONE 4'h1
`define UFC_ID_LINE 4'h6
`define UFC_ID_DATA 4'h4
`define UFC_ID_TOUT 4'hC
`define UFC_ID_THRE 4'h2
`define UFC_ID_MODEM 4'h0
`define UFC_IIR_FIFO_BITS 2'h3

// Interrupt enable fields
`define UFC_IER_DATA 0
`define UFC_IER_THRE 1
`define UFC_IER_LINE 2
`define UFC_IER_MODEM 3

// Modem control fields
`define UFC_MCR_DTR 0
`define UFC_MCR_RTS 1
`define UFC_MCR_SPARE 2
`define UFC_MCR_IRQEN 3
`define UFC_MCR_LOOP 4

// Widths, reset values and timing
`define UFC_CNT_W 5
`define UFC_SYNC_W 5
`define UFC_TO_CHARS 3'h4
`define UFC_ZERO8 8'h00
`define UFC_ZERO4 4'h0

`endif

// ===== src/ufc_pkg.sv
// Types shared by the UART control block and its helpers
package ufc_pkg;

  // Interrupt source indicated to software
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_LINE,
    SRC_DATA,
    SRC_TOUT,
    SRC_THRE,
    SRC_MODEM
  } ufc_src_t;

  // Events and levels reported by the rest of the UART (same clock)
  typedef struct packed {
    logic rx_push;
    logic rx_read;
    logic thr_write;
    logic lsr_read;
    logic msr_read;
    logic line_err;
    logic tx_empty;
    logic char_tick;
  } ufc_evt_t;

  // Controls handed to the FIFOs and the receiver
  typedef struct packed {
    logic fifo_mode;
    logic rx_flush;
    logic tx_flush;
    logic [1:0] trig_sel;
    logic loopback;
  } ufc_ctl_t;

endpackage

// ===== src/ufc_sync.sv
// Two-flop synchroniser for the serial and modem input pins
`timescale 1ns/10ps
`include "ufc_defines.svh"

module ufc_sync
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Asynchronous inputs and synchronised copies
  input wire logic [`UFC_SYNC_W-1:0] async_i,
  output logic [`UFC_SYNC_W-1:0] sync_o
);

  logic [`UFC_SYNC_W-1:0] stage1;

  genvar gi;
  generate
    for (gi = 0; gi < `UFC_SYNC_W; gi = gi + 1)
    begin : g_bit
      // Pins idle high, so reset to the inactive level
      always_ff @(posedge clk_sys_i)
      begin
        if (!nrst_i)
        begin
          stage1[gi] <= 1'b1;
          sync_o[gi] <= 1'b1;
        end
        else
        begin
          stage1[gi] <= async_i[gi];
          sync_o[gi] <= stage1[gi];
        end
      end
    end
  endgenerate

endmodule

// ===== src/ufc_timeout.sv
// Character time-out detector for the receive FIFO
`timescale 1ns/10ps
`include "ufc_defines.svh"

module ufc_timeout
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Conditions
  input wire logic fifo_mode_i,
  input wire logic rx_nonempty_i,
  input wire logic activity_i,
  input wire logic char_tick_i,
  input wire logic clear_i,
  // Time-out indication
  output logic timeout_o
);

  logic [2:0] char_cnt;
  wire logic idle_run = fifo_mode_i && rx_nonempty_i && !activity_i;
  wire logic expire = idle_run && char_tick_i && (char_cnt == (`UFC_TO_CHARS - 3'h1));

  // Any push or pop restarts the count of idle character times
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i || !idle_run)
      char_cnt <= 3'h0;
    else if (char_tick_i && char_cnt != `UFC_TO_CHARS)
      char_cnt <= char_cnt + 3'h1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
      timeout_o <= 1'b0;
    else if (expire)
      timeout_o <= 1'b1;
    else if (clear_i || !fifo_mode_i || !rx_nonempty_i)
      timeout_o <= 1'b0;
  end

endmodule

// ===== tb/tb.sv
// Self-checking bench for the UART control block
`timescale 1ns/10ps
module tb;
  logic clk_sys_i = 0, nrst_i = 0, hsel_i = 1, hwrite_i = 0, tx_shift_i = 1;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, d;
  logic [1:0] htrans_i = 0;
  logic [2:0] hsize_i = 3'h2;
  logic [4:0] rx_count_i = 0;
  logic [3:0] modem_lines_o;
  ufc_pkg::ufc_evt_t evt_i = '0;
  ufc_pkg::ufc_ctl_t ctl_o;
  logic hreadyout_o, hresp_o, rx_serial_o, serial_in_pin_i, cts_n_i, dsr_n_i;
  logic bell_signal_in_n_i, carrier_detect_in_n_i, serial_out_pin_o, dtr_n_o, rts_n_o;
  logic interrupt_line_a_o, interrupt_line_a_oe_o, interrupt_line_b_o, interrupt_line_b_oe_o;
  logic ring = 0, carrier = 1;
  int err_total = 0, checks_done = 0, cyc = 0, interrupt_mask = 0, fen = 0, lvl = 1, lf = 0, tf = 0;
  int tof = 0, mf = 0, v;
  int lv[4] = '{1, 4, 8, 14};
  always #12.5 clk_sys_i = ~clk_sys_i;
  ufc_ctrl dut_u (.clk_sys_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .evt_i,
    .rx_count_i, .tx_shift_i, .ctl_o, .rx_serial_o, .modem_lines_o, .serial_in_pin_i,
    .cts_n_i, .dsr_n_i, .bell_signal_in_n_i, .carrier_detect_in_n_i, .serial_out_pin_o,
    .dtr_n_o, .rts_n_o, .interrupt_line_a_o, .interrupt_line_a_oe_o, .interrupt_line_b_o,
    .interrupt_line_b_oe_o);
  ufc_line_peer peer_u (.clk_sys_i, .serial_out_i(serial_out_pin_o), .dtr_n_i(dtr_n_o),
    .rts_n_i(rts_n_o), .ring_i(ring), .carrier_i(carrier), .serial_in_o(serial_in_pin_i),
    .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i), .bell_n_o(bell_signal_in_n_i),
    .carrier_n_o(carrier_detect_in_n_i));
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  // One single transfer; the wait ends only on hready
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] wd);
    @(posedge clk_sys_i);
    haddr_i <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= w;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    d = hrdata_o;
  endtask
  function automatic logic [31:0] exp_id();
    logic [3:0] c;
    c = (interrupt_mask[2] && lf) ? 4'h6 :
      (interrupt_mask[0] && (fen ? rx_count_i >= lvl : rx_count_i > 0)) ? 4'h4 :
      (interrupt_mask[0] && tof) ? 4'hC :
      (interrupt_mask[1] && tf) ? 4'h2 : (interrupt_mask[3] && mf) ? 4'h0 : 4'h1;
    return {24'h0, fen ? 2'h3 : 2'h0, 2'h0, c};
  endfunction
  task automatic interrupt_ident();
    logic [31:0] e;
    e = exp_id();
    xfer(1'b0, 8'h08, 32'h0);
    chk("ident", d, e);
    if (e[3:0] == 4'h2)
      tf = 0;
  endtask
  task automatic pulse(int b);
    @(posedge clk_sys_i);
    evt_i[b] <= 1'b1;
    @(posedge clk_sys_i);
    evt_i[b] <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic setc(int n);
    @(posedge clk_sys_i);
    rx_count_i <= 5'(n);
    repeat (3) @(posedge clk_sys_i);
  endtask
  initial
  begin
    v = $urandom(32'hB189);
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    // The carrier level reaches the status view only after the synchroniser
    repeat (4) @(posedge clk_sys_i);
    pulse(3);
    xfer(1'b0, 8'h04, 0);
    chk("mask", d, 0);
    xfer(1'b0, 8'h10, 0);
    chk("modem", d, 0);
    interrupt_ident();
    xfer(1'b0, 8'h40, 0);
    chk("unmapped", d, 0);
    v = $urandom;
    xfer(1'b1, 8'h04, v);
    xfer(1'b0, 8'h04, 0);
    chk("mask", d, v & 32'hF);
    v = ($urandom & 32'hFFFFFFEC) | 3;
    xfer(1'b1, 8'h10, v);
    xfer(1'b0, 8'h10, 0);
    chk("modem", d, v & 32'hF);
    chk("dtr", dtr_n_o, 0);
    chk("rts", rts_n_o, 0);
    mf = 1;
    interrupt_mask = 8;
    xfer(1'b1, 8'h04, interrupt_mask);
    repeat (12) @(posedge clk_sys_i);
    chk("lines", modem_lines_o, 4'hB);
    interrupt_ident();
    chk("irq", interrupt_line_a_o, v[3]);
    pulse(3);
    mf = 0;
    interrupt_ident();
    xfer(1'b1, 8'h08, 32'hC6);
    #1 chk("ctl", ctl_o, 0);
    xfer(1'b1, 8'h08, 32'h01);
    fen = 1;
    #1 chk("ctl", ctl_o, 6'h38);
    interrupt_mask = 1;
    xfer(1'b1, 8'h04, interrupt_mask);
    for (int t = 0; t < 4; t++)
    begin
      xfer(1'b1, 8'h08, (t << 6) | 1);
      lvl = lv[t];
      setc(lvl - 1);
      interrupt_ident();
      setc(lvl + $urandom_range(0, 16 - lvl));
      interrupt_ident();
    end
    xfer(1'b1, 8'h08, 32'h0B);
    lvl = 1;
    #1 chk("ctl", ctl_o, 6'h30);
    @(posedge clk_sys_i);
    #1 chk("ctl", ctl_o, 6'h20);
    xfer(1'b1, 8'h08, 32'h35);
    #1 chk("ctl", ctl_o, 6'h28);
    setc(0);
    interrupt_mask = 15;
    xfer(1'b1, 8'h04, interrupt_mask);
    evt_i.tx_empty <= 1'b1;
    setc(1);
    tf = 1;
    pulse(2);
    lf = 1;
    ring <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    ring <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    mf = 1;
    interrupt_ident();
    pulse(4);
    lf = 0;
    interrupt_ident();
    setc(0);
    interrupt_ident();
    interrupt_ident();
    pulse(3);
    mf = 0;
    interrupt_ident();
    evt_i.tx_empty <= 1'b0;
    pulse(5);
    evt_i.tx_empty <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    tf = 1;
    pulse(5);
    tf = 0;
    interrupt_ident();
    xfer(1'b1, 8'h08, 32'h41);
    lvl = 4;
    setc(1);
    repeat (3) pulse(0);
    interrupt_ident();
    pulse(0);
    tof = 1;
    interrupt_ident();
    pulse(6);
    tof = 0;
    interrupt_ident();
    xfer(1'b1, 8'h08, 32'h01);
    lvl = 1;
    interrupt_mask = 14;
    xfer(1'b1, 8'h04, interrupt_mask);
    xfer(1'b1, 8'h10, 32'h0B);
    interrupt_ident();
    chk("irq", interrupt_line_a_o, 0);
    interrupt_mask = 1;
    xfer(1'b1, 8'h04, interrupt_mask);
    repeat (3) @(posedge clk_sys_i);
    chk("irq", interrupt_line_a_o, 1);
    xfer(1'b1, 8'h10, 32'h00);
    repeat (3) @(posedge clk_sys_i);
    chk("irq", interrupt_line_a_o, 0);
    xfer(1'b1, 8'h08, 32'h00);
    fen = 0;
    repeat (4) pulse(0);
    interrupt_ident();
    tx_shift_i <= 1'b0;
    xfer(1'b1, 8'h10, 32'h15);
    repeat (4) @(posedge clk_sys_i);
    chk("pins", {dtr_n_o, rts_n_o, serial_out_pin_o, rx_serial_o}, 4'hE);
    chk("lines", modem_lines_o, 4'h6);
    chk("oe", interrupt_line_a_oe_o, 0);
    tx_shift_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk("rx", rx_serial_o, 1);
    summarize();
  end
endmodule

// ===== tb/ufc_ctrl_chk.sv
// Assertion checker for the UART control block ports
`timescale 1ns/10ps
module ufc_chk
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Watched ports
  input wire logic tx_shift_i,
  input wire ufc_pkg::ufc_ctl_t ctl_o,
  input wire logic rx_serial_o,
  input wire logic serial_out_pin_o,
  input wire logic dtr_n_o,
  input wire logic rts_n_o,
  input wire logic interrupt_line_a_o,
  input wire logic interrupt_line_a_oe_o,
  input wire logic interrupt_line_b_o,
  input wire logic interrupt_line_b_oe_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  a_loop_pins_high: assert property ($past(nrst_i) && $past(ctl_o.loopback) |->
    dtr_n_o && rts_n_o && serial_out_pin_o) else $error("loopback pins not high");
  a_loop_rx_path: assert property ($past(nrst_i) && $past(ctl_o.loopback) |->
    rx_serial_o == $past(tx_shift_i)) else $error("loopback data not routed");
  a_tx_pass: assert property ($past(nrst_i) && !$past(ctl_o.loopback) |->
    serial_out_pin_o == $past(tx_shift_i)) else $error("serial out wrong");
  a_loop_irq_float: assert property ($past(nrst_i) && $past(ctl_o.loopback) |->
    !interrupt_line_a_oe_o && !interrupt_line_b_oe_o) else $error("irq pins driven");
  a_irq_drive_normal: assert property ($past(nrst_i) && !$past(ctl_o.loopback) |->
    interrupt_line_a_oe_o && interrupt_line_b_oe_o) else $error("irq pins floating");
  a_rxflush_once: assert property (ctl_o.rx_flush |=> !ctl_o.rx_flush)
    else $error("rx flush held");
  a_txflush_once: assert property (ctl_o.tx_flush |=> !ctl_o.tx_flush)
    else $error("tx flush held");
  a_mode_flush_both: assert property ($changed(ctl_o.fifo_mode) |->
    ##[0:1] (ctl_o.rx_flush && ctl_o.tx_flush)) else $error("mode change kept data");
  a_trig_needs_en: assert property ($changed(ctl_o.trig_sel) |->
    ctl_o.fifo_mode && $past(ctl_o.fifo_mode)) else $error("trigger set while off");
  a_irq_pair: assert property (interrupt_line_b_o == interrupt_line_a_o)
    else $error("irq lines differ");
  c_loop: cover property ($past(ctl_o.loopback) && !interrupt_line_a_oe_o);
  c_irq: cover property (interrupt_line_a_o);
  c_flush: cover property (ctl_o.rx_flush && !ctl_o.tx_flush);
endmodule
bind ufc_ctrl ufc_chk chk_u (.clk_sys_i, .nrst_i, .tx_shift_i, .ctl_o, .rx_serial_o,
  .serial_out_pin_o, .dtr_n_o, .rts_n_o, .interrupt_line_a_o, .interrupt_line_a_oe_o,
  .interrupt_line_b_o, .interrupt_line_b_oe_o);

// ===== tb/ufc_line_peer.sv
// Line-side peripheral model facing the UART pins
`timescale 1ns/10ps
module ufc_line_peer
#(
  parameter int CTS_DLY = 5
)
(
  // Clock
  input wire logic clk_sys_i,
  // From the UART pins
  input wire logic serial_out_i,
  input wire logic dtr_n_i,
  input wire logic rts_n_i,
  // Bench-set line levels
  input wire logic ring_i,
  input wire logic carrier_i,
  // To the UART pins
  output logic serial_in_o,
  output logic cts_n_o,
  output logic dsr_n_o,
  output logic bell_n_o,
  output logic carrier_n_o
);
  int wait_cnt = 0;
  // A plain modem echoes the line and is ready as soon as the terminal is
  assign serial_in_o = serial_out_i;
  assign dsr_n_o = dtr_n_i;
  assign bell_n_o = ~ring_i;
  assign carrier_n_o = ~carrier_i;
  // Clear-to-send is granted late, so the UART sees a slow peer
  always @(posedge clk_sys_i)
    wait_cnt <= rts_n_i ? 0 : wait_cnt + 1;
  assign cts_n_o = !(wait_cnt > CTS_DLY);
endmodule
